// >>> core/dual_adc_serial_port.sv
// serial port of a dual simultaneous-sampling converter with a bus slave
// What this block does
// - select falling edge samples both inputs, starts both conversions, drives lanes
// - conversion timed by own clock, never by serial clock
// - lane select 0: A result on lane a, B result on lane b
// - one-lane mode: A then B both on lane a
// - frame returns previous conversion; same falling edge starts the next
// - MSB shown at select fall, next bits on serial clock rising edges
// - host raises select after last falling edge; lanes then released
// - second select after conversion time returns the fresh result
// - read command: D15 low, address D14:D12; data returned next frame
// - write command: D15 high, address D14:D12, data D11:D0
// - write access is 16 bits, or 24 with write checksum on
// - read and write checksums enabled by separate bits
// - read checksum of 8 bits on lane a over results or register data
// - read checksum works in both lane modes and with resolution boost
// - write enabling write checksum must carry valid checksum itself
// - with write checksum on, writes lacking valid checksum are ignored
// - checksum polynomial x^8+x^2+x+1
// - result checksum over joined results, top byte inverted
// - boost bit plus oversampling gives 18-bit results
// - unlisted writes ignored; unlisted reads act as no-operation
`timescale 1ns/100ps
`default_nettype none
module dual_adc_serial_port (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter sample inputs and sample strobe
  input wire logic [17:0] conv_a_in,
  input wire logic [17:0] conv_b_in,
  output logic sample_hold,
  // serial pins
  input wire logic frame_select_n,
  input wire logic serial_clock,
  input wire logic serial_command_in,
  output logic result_lane_a,
  output logic result_lane_a_oe,
  output logic result_lane_b_or_flag,
  output logic result_lane_b_or_flag_oe
);
  import adc_port_pkg::*;

  function automatic logic [7:0] crc8(input logic [35:0] d, input logic [5:0] n);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 0; i < 36; i++) begin
      if (i < int'(n)) begin
        fb = c[7] ^ d[35 - i];
        c = {c[6:0], 1'b0};
        if (fb) begin
          c = c ^ CRC_POLY;
        end
      end
    end
    return c;
  endfunction

  // pin synchronisers: change counts once second and third stage agree
  logic [2:0] cs_s, sck_s, sdi_s;
  logic cs_f, sck_f, sdi_f, cs_d, sck_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      cs_f <= 1'b1;
      sck_f <= 1'b0;
      sdi_f <= 1'b0;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else if (clk_en) begin
      cs_s <= {cs_s[1:0], frame_select_n};
      sck_s <= {sck_s[1:0], serial_clock};
      sdi_s <= {sdi_s[1:0], serial_command_in};
      if (cs_s[1] == cs_s[2]) cs_f <= cs_s[2];
      if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
      if (sdi_s[1] == sdi_s[2]) sdi_f <= sdi_s[2];
      cs_d <= cs_f;
      sck_d <= sck_f;
    end
  end

  logic port_en;
  logic cs_fall, cs_rise, sck_rise, sck_fall, in_frame;
  assign cs_fall = cs_d & ~cs_f & port_en;
  assign cs_rise = ~cs_d & cs_f;
  assign in_frame = ~cs_f;
  assign sck_rise = in_frame & ~sck_d & sck_f;
  assign sck_fall = in_frame & sck_d & ~sck_f;

  // configuration words
  logic [11:0] cfg_one, cfg_two;
  logic crc_w_on, crc_r_on, wide, one_lane;
  assign crc_w_on = cfg_one[CRC_W_BIT];
  assign crc_r_on = cfg_one[CRC_R_BIT];
  assign wide = cfg_one[RES_BIT] & (cfg_one[OSR_HI:OSR_LO] != 3'h0);
  assign one_lane = cfg_two[LANE_BIT];

  // conversion engine on the block clock
  logic [17:0] hold_a, hold_b, result_a, result_b;
  logic [7:0] conv_cnt;
  logic conv_busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_a <= 18'h0;
      hold_b <= 18'h0;
      result_a <= 18'h0;
      result_b <= 18'h0;
      conv_cnt <= 8'h0;
      conv_busy <= 1'b0;
      sample_hold <= 1'b0;
    end else if (clk_en) begin
      sample_hold <= cs_fall;
      if (cs_fall) begin
        hold_a <= conv_a_in;
        hold_b <= conv_b_in;
        conv_cnt <= 8'(CONVERT_CYCLES - 1);
        conv_busy <= 1'b1;
      end else if (conv_busy) begin
        if (conv_cnt == 8'h0) begin
          conv_busy <= 1'b0;
          result_a <= hold_a;
          result_b <= hold_b;
        end else begin
          conv_cnt <= conv_cnt - 8'h1;
        end
      end
    end
  end

  // frame contents loaded at select fall
  logic read_pend;
  logic [11:0] read_data;
  logic [2:0] read_addr;
  logic [35:0] crc_word;
  logic [5:0] crc_len;
  logic [7:0] crc_out;
  logic [43:0] frame_a;
  logic [17:0] frame_b;
  always_comb begin
    if (read_pend) begin
      crc_word = {1'b0, read_addr, read_data, 20'h0};
      crc_len = 6'd16;
    end else if (wide) begin
      crc_word = {result_a, result_b};
      crc_len = 6'd36;
    end else begin
      crc_word = {result_a[17:2], result_b[17:2], 4'h0};
      crc_len = 6'd32;
    end
    crc_out = crc_r_on ? crc8(crc_word, crc_len) : 8'h00;
    frame_b = 18'h0;
    if (read_pend) begin
      frame_a = {1'b0, read_addr, read_data, crc_out, 20'h0};
    end else if (one_lane) begin
      frame_a = wide ? {result_a, result_b, crc_out}
                     : {result_a[17:2], result_b[17:2], crc_out, 4'h0};
    end else begin
      frame_a = wide ? {result_a, crc_out, 18'h0} : {result_a[17:2], crc_out, 20'h0};
      frame_b = wide ? result_b : {result_b[17:2], 2'h0};
    end
  end

  // output shifters and lane drivers
  logic [43:0] sh_a;
  logic [17:0] sh_b;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_a <= 44'h0;
      sh_b <= 18'h0;
      result_lane_a <= 1'b0;
      result_lane_b_or_flag <= 1'b0;
      result_lane_a_oe <= 1'b0;
      result_lane_b_or_flag_oe <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        sh_a <= frame_a;
        sh_b <= frame_b;
        result_lane_a <= frame_a[43];
        result_lane_b_or_flag <= frame_b[17];
        result_lane_a_oe <= 1'b1;
        result_lane_b_or_flag_oe <= 1'b1;
      end else if (cs_rise) begin
        result_lane_a_oe <= 1'b0;
        result_lane_b_or_flag_oe <= 1'b0;
      end else if (sck_rise) begin
        sh_a <= {sh_a[42:0], 1'b0};
        sh_b <= {sh_b[16:0], 1'b0};
        result_lane_a <= sh_a[42];
        result_lane_b_or_flag <= sh_b[16];
      end
    end
  end

  // command receiver, sampled on serial clock falling edges
  logic [23:0] in_sh;
  logic [4:0] in_cnt;
  logic [15:0] cmd;
  logic [7:0] cmd_crc;
  logic [7:0] reject_cnt;
  logic cmd_full, crc_ok, cmd_ok, wr_ok;
  assign cmd_full = in_cnt >= CMD_BITS;
  assign crc_ok = (in_cnt >= CMD_CRC_BITS) && (cmd_crc == crc8({cmd, 20'h0}, 6'd16));
  assign cmd_ok = cmd_full & cmd[CMD_WRITE_BIT];
  // enabling write checksum or writing while it is on needs a valid checksum
  assign wr_ok = cmd_ok & ((crc_w_on | (cmd[14:12] == ADDR_CFG_ONE && cmd[CRC_W_BIT])) ? crc_ok : 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sh <= 24'h0;
      in_cnt <= 5'h0;
      cmd <= 16'h0;
      cmd_crc <= 8'h0;
    end else if (clk_en) begin
      // cleared at select rise too, so a frame the port ignores cannot apply an old command again
      if (cs_fall || cs_rise) begin
        in_cnt <= 5'h0;
      end else if (sck_fall && in_cnt != CMD_CRC_BITS) begin
        in_sh <= {in_sh[22:0], sdi_f};
        in_cnt <= in_cnt + 5'h1;
        if (in_cnt == CMD_BITS - 5'h1) cmd <= {in_sh[14:0], sdi_f};
        if (in_cnt == CMD_CRC_BITS - 5'h1) cmd_crc <= {in_sh[6:0], sdi_f};
      end
    end
  end

  // register writes and read requests take effect at select rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_one <= CFG_ONE_RESET;
      cfg_two <= CFG_TWO_RESET;
      read_pend <= 1'b0;
      read_addr <= 3'h0;
      read_data <= 12'h0;
      reject_cnt <= 8'h0;
    end else if (clk_en) begin
      if (cs_fall) begin
        read_pend <= 1'b0;
      end else if (cs_rise && cmd_full) begin
        if (cmd[CMD_WRITE_BIT]) begin
          if (!wr_ok) begin
            reject_cnt <= reject_cnt + 8'h1;
          end else if (cmd[14:12] == ADDR_CFG_ONE) begin
            cfg_one <= cmd[11:0];
          end else if (cmd[14:12] == ADDR_CFG_TWO) begin
            cfg_two <= cmd[11:0];
          end
        end else if (cmd[14:12] == ADDR_CFG_ONE || cmd[14:12] == ADDR_CFG_TWO) begin
          read_pend <= 1'b1;
          read_addr <= cmd[14:12];
          read_data <= (cmd[14:12] == ADDR_CFG_ONE) ? cfg_one : cfg_two;
        end
      end
    end
  end

  // bus slave: one write and one read at a time
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      port_en <= CTRL_RESET;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (!aw_hold && !s_axi_bvalid && s_axi_awvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (!w_hold && !s_axi_bvalid && s_axi_wvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr[7:2] == CTRL_OFS[7:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb[0]) port_en <= w_data[0];
        end else if (aw_addr[7:2] <= RESULT_OFS[7:2]) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr[7:2])
          CTRL_OFS[7:2]: s_axi_rdata <= {31'h0, port_en};
          STATUS_OFS[7:2]: s_axi_rdata <= {16'h0, reject_cnt, 2'h0, wide, one_lane,
                                           crc_w_on, crc_r_on, read_pend, conv_busy};
          CFG_ONE_OFS[7:2]: s_axi_rdata <= {20'h0, cfg_one};
          CFG_TWO_OFS[7:2]: s_axi_rdata <= {20'h0, cfg_two};
          RESULT_OFS[7:2]: s_axi_rdata <= {result_a[17:2], result_b[17:2]};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> inc/adc_port_pkg.sv
// constants shared by the dual converter serial port
package adc_port_pkg;
  // bus register byte offsets and control reset value
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CFG_ONE_OFS = 8'h08;
  localparam logic [7:0] CFG_TWO_OFS = 8'h0c;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [0:0] CTRL_RESET = 1'h1;
  // serial register addresses and reset values
  localparam logic [2:0] ADDR_CFG_ONE = 3'h1;
  localparam logic [2:0] ADDR_CFG_TWO = 3'h2;
  localparam logic [11:0] CFG_ONE_RESET = 12'h000;
  localparam logic [11:0] CFG_TWO_RESET = 12'h000;
  // field positions
  localparam int CRC_W_BIT = 5;
  localparam int CRC_R_BIT = 4;
  localparam int RES_BIT = 2;
  localparam int OSR_HI = 8;
  localparam int OSR_LO = 6;
  localparam int LANE_BIT = 8;
  localparam int CMD_WRITE_BIT = 15;
  // checksum
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [4:0] CMD_BITS = 5'h10;
  localparam logic [4:0] CMD_CRC_BITS = 5'h18;
  // conversion timing and bus response codes
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONVERT_TIME_NS = 500;
  localparam int CONVERT_CYCLES = (CONVERT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> sim/dual_adc_serial_port_asserts.sv
// port assertions for the dual converter serial port
`timescale 1ns/100ps
`default_nettype none
module dual_adc_serial_port_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus responses
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // serial side
  input wire logic sample_hold,
  input wire logic frame_select_n,
  input wire logic serial_clock,
  input wire logic result_lane_a,
  input wire logic result_lane_a_oe,
  input wire logic result_lane_b_or_flag_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_idle_high;
    frame_select_n [*8];
  endsequence
  sequence s_quiet_low;
    (!serial_clock && !frame_select_n) [*6] ##1 (result_lane_a_oe && $past(result_lane_a_oe));
  endsequence
  property p_hold_pulse; sample_hold |=> !sample_hold; endproperty
  a_hold_pulse: assert property (p_hold_pulse) else $error("sample pulse too long");
  property p_hold_cause; sample_hold |-> $past(frame_select_n, 4) == 1'b0; endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("sample without select low");
  property p_oe_on; sample_hold |-> ##[0:2] result_lane_a_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("lane not driven after sample");
  property p_b_with_a; result_lane_a_oe |-> result_lane_b_or_flag_oe; endproperty
  a_b_with_a: assert property (p_b_with_a) else $error("lane b not driven with lane a");
  property p_oe_off; s_idle_high |-> !result_lane_a_oe && !result_lane_b_or_flag_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("lanes driven outside frame");
  property p_bit_hold; s_quiet_low |-> $stable(result_lane_a); endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("lane a moved without clock rise");
  property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped early");
  property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_stand: assert property (p_r_stand) else $error("read response dropped early");
endmodule
bind dual_adc_serial_port dual_adc_serial_port_asserts chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_hold, .frame_select_n, .serial_clock,
  .result_lane_a, .result_lane_a_oe, .result_lane_b_or_flag_oe);
`default_nettype wire

// >>> sim/spi_host_model.sv
// serial master that frames accesses and captures both lanes
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // lanes from the port
  input wire logic result_lane_a,
  input wire logic result_lane_a_oe,
  input wire logic result_lane_b_or_flag,
  // master pins
  output logic frame_select_n,
  output logic serial_clock,
  output logic serial_command_in
);
  logic [43:0] ra, rb;
  logic saw_oe;
  initial begin
    frame_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_command_in = 1'b0;
  end
  task automatic xfer(input logic [23:0] cmd, input int n);
    #7;
    ra = '0;
    rb = '0;
    saw_oe = 1'b0;
    frame_select_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      // bit is taken just before the rise that moves it on
      // a released lane a is seen as the inverse of its last level
      ra = {ra[42:0], result_lane_a_oe ? result_lane_a : ~result_lane_a};
      rb = {rb[42:0], result_lane_b_or_flag};
      saw_oe = saw_oe | result_lane_a_oe;
      serial_clock = 1'b1;
      serial_command_in = (i < 24) ? cmd[23-i] : 1'b0;
      #80;
      serial_clock = 1'b0;
      #80;
    end
    frame_select_n = 1'b1;
    serial_command_in = ~serial_command_in;
    #400;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the dual converter serial port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin tests_run++; if ((s)!==(e)) begin fail_count++; $display("MISMATCH %s exp %h got %h",n,e,s); end end
module tb_top;
  import adc_port_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_hold;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [17:0] conv_a_in = '0, conv_b_in = '0;
  logic frame_select_n, serial_clock, serial_command_in;
  logic result_lane_a, result_lane_a_oe, result_lane_b_or_flag, result_lane_b_or_flag_oe;
  int fail_count = 0, tests_run = 0, cycles = 0;
  logic [35:0] rows [4] = '{36'h123456789, 36'hfffffffff, 36'h000000000, 36'ha5a5c3c3c};
  dual_adc_serial_port dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv_a_in, .conv_b_in, .sample_hold, .frame_select_n, .serial_clock, .serial_command_in,
    .result_lane_a, .result_lane_a_oe, .result_lane_b_or_flag, .result_lane_b_or_flag_oe);
  spi_host_model host (.result_lane_a, .result_lane_a_oe, .result_lane_b_or_flag, .frame_select_n,
    .serial_clock, .serial_command_in);
  always #10 aclk = ~aclk;
  function automatic logic [7:0] crc8(input logic [35:0] d, input int n);
    logic [7:0] r;
    logic fb;
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      // the message's top byte goes in inverted
      fb = r[7] ^ d[i] ^ (i >= n - 8);
      r = {r[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return r;
  endfunction
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("axi_read", {er, e}, {s_axi_rresp, s_axi_rdata & m})
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    logic [15:0] c;
    logic [31:0] v;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK("reset_out", 3'b000, {result_lane_a_oe, s_axi_bvalid, sample_hold})
    repeat (6) @(posedge aclk);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h1, RESP_OKAY);
    rd_chk(CFG_ONE_OFS, 32'hffffffff, 32'h0, RESP_OKAY);
    rd_chk(CFG_TWO_OFS, 32'hffffffff, 32'h0, RESP_OKAY);
    rd_chk(8'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      conv_a_in <= rows[i][35:18];
      conv_b_in <= rows[i][17:0];
      host.xfer(24'h0, 16);
      `CHK("lane_on", 1'b1, host.saw_oe)
      if (i > 0) begin
        `CHK("lane_a", rows[i-1][35:20], host.ra[15:0])
        `CHK("lane_b", rows[i-1][17:2], host.rb[15:0])
      end
    end
    v = {rows[3][35:20], rows[3][17:2]};
    host.xfer({1'b1, ADDR_CFG_TWO, 12'h100, 8'h00}, 10);
    rd_chk(CFG_TWO_OFS, 32'hfff, 32'h0, RESP_OKAY);
    host.xfer({1'b1, ADDR_CFG_TWO, 12'h100, 8'h00}, 16);
    rd_chk(CFG_TWO_OFS, 32'hfff, 32'h100, RESP_OKAY);
    host.xfer(24'h0, 32);
    `CHK("one_lane", v, host.ra[31:0])
    host.xfer({1'b1, ADDR_CFG_ONE, 12'h010, 8'h00}, 16);
    host.xfer(24'h0, 40);
    `CHK("crc_read", {v, crc8(v, 32)}, host.ra[39:0])
    host.xfer({1'b0, ADDR_CFG_TWO, 12'h000, 8'h00}, 40);
    host.xfer(24'h0, 24);
    `CHK("reg_read", {16'h2100, crc8(32'h2100, 16)}, host.ra[23:0])
    c = {1'b1, ADDR_CFG_ONE, 12'h030};
    host.xfer({c, 8'h00}, 16);
    rd_chk(CFG_ONE_OFS, 32'hfff, 32'h010, RESP_OKAY);
    host.xfer({c, crc8({16'h0, c}, 16)}, 24);
    rd_chk(CFG_ONE_OFS, 32'hfff, 32'h030, RESP_OKAY);
    c = {1'b1, ADDR_CFG_ONE, 12'h010};
    host.xfer({c, ~crc8({16'h0, c}, 16)}, 24);
    rd_chk(CFG_ONE_OFS, 32'hfff, 32'h030, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h0);
    host.xfer(24'h0, 16);
    `CHK("lane_off", 1'b0, host.saw_oe)
    rd_chk(STATUS_OFS, 32'hffff, 32'h021c, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h1);
    c = {1'b1, ADDR_CFG_ONE, 12'h074};
    host.xfer({c, crc8({16'h0, c}, 16)}, 24);
    host.xfer(24'h0, 44);
    `CHK("boost_one_lane", {rows[3], crc8(rows[3], 36)}, host.ra[43:0])
    c = {1'b1, ADDR_CFG_TWO, 12'h000};
    host.xfer({c, crc8({16'h0, c}, 16)}, 24);
    host.xfer(24'h0, 26);
    `CHK("boost_lane_a", {rows[3][35:18], crc8(rows[3], 36)}, host.ra[25:0])
    `CHK("boost_lane_b", rows[3][17:0], host.rb[25:8])
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h1, RESP_OKAY);
    rd_chk(CFG_ONE_OFS, 32'hfff, 32'h0, RESP_OKAY);
    rd_chk(STATUS_OFS, 32'hffff, 32'h0, RESP_OKAY);
    test_done();
  end
endmodule
`default_nettype wire
